// ==== rtl/serial_register_access_front_end.sv ====
/*
 * Serial register access front end: command byte decode, bit-exact data
 * phases, resynchronising reset and channel-to-input mapping.
 * Assumes the host drives sclk_i (idle high), cs_n_i and din_i, and that
 * core logic on clk_i answers reads through rd_data_i.
 */
// Summary of operation
// - the write-only command register never appears on the serial output.
// - after the command the device shifts exactly the width of the register, 8 to 24 bits.
// - after reset or a finished transfer the interface waits for a new command.
// - 32 clocks with select low and data in high reset the interface and all registers.
// - command bit 6 picks write (0) or read (1) for the following transfer.
// - command bits 5 to 0 are the address of the register accessed next.
// - low address bits give the channel; single-ended n uses input n, differential uses a pair.
// - each channel's two-bit input configuration picks single-ended or differential.
// - the mode register is aliased at eight addresses and the write address picks its channel.
`timescale 1ns/100ps
module serial_register_access_front_end
  import sra_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic wr_strobe_o,
  output logic [5:0] wr_addr_o,
  output logic [23:0] wr_data_o,
  output logic rd_strobe_o,
  output logic [5:0] rd_addr_o,
  input wire logic [23:0] rd_data_i,
  output logic soft_reset_o,
  output logic [7:0] mode_o,
  output logic [2:0] mode_channel_o,
  output logic [2:0] pos_input_o,
  output logic [2:0] neg_input_o,
  output logic neg_is_common_o
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain (sclk_i)
  logic link_reset;
  link_state_t state;
  logic [4:0] cnt;
  logic [4:0] wr_len;
  logic [23:0] shift_in;
  logic [5:0] cmd_addr;
  logic [5:0] ones;
  logic resync_hit;
  logic wr_tgl;
  logic rd_tgl;
  logic rs_tgl;
  wr_word_t wr_word;
  rd_word_t rd_hold;
  logic [23:0] out_shift;
  logic loaded;
  logic [7:0] next_cmd;

  sync3 u_link_reset (
    .clk_i(sclk_i),
    .reset_i(1'b0),
    .d_i(reset_i),
    .q_o(link_reset)
  );

  assign next_cmd = {shift_in[6:0], din_i};
  assign resync_hit = !cs_n_i && din_i && (ones == RESYNC_ONES - 6'h01);

  // run-of-ones detector
  always_ff @(posedge sclk_i) begin
    if (link_reset || cs_n_i || !din_i || resync_hit) begin
      ones <= 6'h00;
    end else begin
      ones <= ones + 6'h01;
    end
  end

  always_ff @(posedge sclk_i) begin
    if (link_reset) begin
      rs_tgl <= 1'b0;
    end else if (resync_hit) begin
      rs_tgl <= ~rs_tgl;
    end
  end

  // frame sequencer, sampling on rising edges
  always_ff @(posedge sclk_i) begin
    if (link_reset || resync_hit) begin
      state <= LINK_CMD;
      cnt <= 5'h00;
      shift_in <= 24'h000000;
      cmd_addr <= ADDR_CMD;
      wr_len <= WIDTH_8;
      // toggles survive a resync: clearing one would fake a core strobe
      if (link_reset) begin
        wr_tgl <= 1'b0;
        rd_tgl <= 1'b0;
      end
      wr_word <= '0;
    end else if (!cs_n_i) begin
      shift_in <= {shift_in[22:0], din_i};
      case (state)
        LINK_CMD: begin
          if (cnt == CMD_BITS - 5'h01) begin
            cnt <= 5'h00;
            cmd_addr <= next_cmd[5:0];
            if (next_cmd[CMD_DIR_BIT]) begin
              state <= LINK_READ;
              rd_tgl <= ~rd_tgl;
            end else begin
              state <= LINK_WRITE;
              wr_len <= reg_width(next_cmd[5:0], 1'b0);
            end
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        LINK_WRITE: begin
          if (cnt == wr_len - 5'h01) begin
            cnt <= 5'h00;
            state <= LINK_CMD;
            wr_word.addr <= cmd_addr;
            wr_word.data <= {shift_in[22:0], din_i} & ~(24'hFFFFFF << wr_len);
            wr_tgl <= ~wr_tgl;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        LINK_READ: begin
          if (cnt == rd_hold.width - 5'h01) begin
            cnt <= 5'h00;
            state <= LINK_CMD;
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        default: state <= LINK_CMD;
      endcase
    end
  end

  // serial output, driven on falling edges; zero outside read phases
  always_ff @(negedge sclk_i) begin
    if (link_reset || state != LINK_READ) begin
      out_shift <= 24'h000000;
      loaded <= 1'b0;
    end else if (!cs_n_i) begin
      if (!loaded) begin
        out_shift <= rd_hold.data << (5'(WORD_BITS) - rd_hold.width);
        loaded <= 1'b1;
      end else begin
        out_shift <= out_shift << 1;
      end
    end
  end

  assign dout_o = out_shift[WORD_BITS-1];

  ////////////////////////////////////////////////////////////////////////////
  // core domain (clk_i)
  logic wr_sync;
  logic rd_sync;
  logic rs_sync;
  logic wr_prev;
  logic rd_prev;
  logic rs_prev;
  logic wr_pulse;
  logic rd_pulse;
  logic rs_pulse;
  logic core_reset;
  logic [1:0] in_cfg [8];
  input_map_t next_map;

  sync3 u_wr_sync (.clk_i(clk_i), .reset_i(reset_i), .d_i(wr_tgl), .q_o(wr_sync));
  sync3 u_rd_sync (.clk_i(clk_i), .reset_i(reset_i), .d_i(rd_tgl), .q_o(rd_sync));
  sync3 u_rs_sync (.clk_i(clk_i), .reset_i(reset_i), .d_i(rs_tgl), .q_o(rs_sync));

  assign wr_pulse = wr_sync != wr_prev;
  assign rd_pulse = rd_sync != rd_prev;
  assign rs_pulse = rs_sync != rs_prev;
  assign core_reset = reset_i || rs_pulse;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
      rs_prev <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      wr_prev <= wr_sync;
      rd_prev <= rd_sync;
      rs_prev <= rs_sync;
      soft_reset_o <= rs_pulse;
    end
  end

  // write hand-off and mode/setup capture
  always_ff @(posedge clk_i) begin
    if (core_reset) begin
      wr_strobe_o <= 1'b0;
      wr_addr_o <= ADDR_CMD;
      wr_data_o <= 24'h000000;
      mode_o <= MODE_RESET;
      mode_channel_o <= 3'h0;
      in_cfg <= '{default: CFG_DIFFERENTIAL};
    end else begin
      wr_strobe_o <= wr_pulse;
      if (wr_pulse) begin
        wr_addr_o <= wr_word.addr;
        wr_data_o <= wr_word.data;
        if (wr_word.addr[5:3] == GRP_MODE) begin
          mode_o <= wr_word.data[7:0];
          mode_channel_o <= wr_word.addr[2:0];
        end
        if (wr_word.addr[5:3] == GRP_SETUP) begin
          in_cfg[wr_word.addr[2:0]] <= wr_word.data[SETUP_CFG_HI:SETUP_CFG_LO];
        end
      end
    end
  end

  // read fetch: address, strobe, then capture with width
  always_ff @(posedge clk_i) begin
    if (core_reset) begin
      rd_strobe_o <= 1'b0;
      rd_addr_o <= ADDR_CMD;
      rd_hold <= '{data: 24'h000000, width: WIDTH_8};
    end else begin
      rd_strobe_o <= rd_pulse;
      if (rd_pulse) begin
        rd_addr_o <= (cmd_addr[5:3] == GRP_MODE) ? ADDR_MODE : cmd_addr;
      end
      if (rd_strobe_o) begin
        rd_hold.width <= reg_width(rd_addr_o, mode_o[MODE_WORD24_BIT]);
        rd_hold.data <= rd_data_i;
      end
    end
  end

  // input mapping of the channel the mode applies to
  assign next_map = chan_map(mode_channel_o, in_cfg[mode_channel_o]);

  always_ff @(posedge clk_i) begin
    if (core_reset) begin
      pos_input_o <= 3'h0;
      neg_input_o <= 3'h0;
      neg_is_common_o <= 1'b0;
    end else begin
      pos_input_o <= next_map.pos;
      neg_input_o <= next_map.neg;
      neg_is_common_o <= next_map.neg_common;
    end
  end

endmodule

// ==== rtl/sra_pkg.sv ====
/*
 * Shared constants, carriers and helpers of the serial register access
 * front end: register map, command layout, field positions, transfer
 * widths and the channel-to-input mapping.
 * Assumes a SystemVerilog tool that accepts automatic functions in packages.
 */
package sra_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (6-bit addresses)
  localparam logic [5:0] ADDR_CMD = 6'h00;
  localparam logic [5:0] ADDR_MODE = 6'h38;
  localparam logic [2:0] GRP_GLOBAL = 3'h0;
  localparam logic [2:0] GRP_DATA = 3'h1;
  localparam logic [2:0] GRP_CH_ZS = 3'h2;
  localparam logic [2:0] GRP_CH_FS = 3'h3;
  localparam logic [2:0] GRP_SETUP = 3'h5;
  localparam logic [2:0] GRP_MODE = 3'h7;
  localparam logic [2:0] IDX_TEST = 3'h3;
  localparam logic [2:0] IDX_CSUM = 3'h5;
  localparam logic [2:0] IDX_ADC_ZS = 3'h6;
  localparam logic [2:0] IDX_ADC_FS = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // command byte layout
  localparam int CMD_DIR_BIT = 6;
  localparam logic [4:0] CMD_BITS = 5'h08;

  // field positions
  localparam int SETUP_CFG_HI = 6;
  localparam int SETUP_CFG_LO = 5;
  localparam int MODE_WORD24_BIT = 1;
  localparam logic [1:0] CFG_DIFFERENTIAL = 2'h0;
  localparam logic [7:0] MODE_RESET = 8'h00;

  // transfer widths
  localparam logic [4:0] WIDTH_8 = 5'h08;
  localparam logic [4:0] WIDTH_16 = 5'h10;
  localparam logic [4:0] WIDTH_24 = 5'h18;
  localparam int WORD_BITS = 24;

  // run of ones that resynchronises the interface
  localparam logic [5:0] RESYNC_ONES = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    LINK_CMD = 2'b00,
    LINK_WRITE = 2'b01,
    LINK_READ = 2'b10
  } link_state_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [23:0] data;
  } wr_word_t;

  typedef struct packed {
    logic [23:0] data;
    logic [4:0] width;
  } rd_word_t;

  typedef struct packed {
    logic [2:0] pos;
    logic [2:0] neg;
    logic neg_common;
  } input_map_t;

  ////////////////////////////////////////////////////////////////////////////
  // number of data bits of the addressed register
  function automatic logic [4:0] reg_width(input logic [5:0] addr, input logic word24);
    logic [4:0] w;
    w = WIDTH_8;
    case (addr[5:3])
      GRP_GLOBAL: begin
        if (addr[2:0] == IDX_TEST || addr[2:0] == IDX_ADC_ZS || addr[2:0] == IDX_ADC_FS) begin
          w = WIDTH_24;
        end else if (addr[2:0] == IDX_CSUM) begin
          w = WIDTH_16;
        end
      end
      GRP_DATA: w = word24 ? WIDTH_24 : WIDTH_16;
      GRP_CH_ZS, GRP_CH_FS: w = WIDTH_24;
      default: w = WIDTH_8;
    endcase
    return w;
  endfunction

  // analog inputs used by a channel for its input configuration
  function automatic input_map_t chan_map(input logic [2:0] chan, input logic [1:0] cfg);
    input_map_t m;
    m = '0;
    if (cfg == CFG_DIFFERENTIAL) begin
      m.pos = {chan[1:0], 1'b0};
      m.neg = {chan[1:0], 1'b1};
      m.neg_common = 1'b0;
    end else begin
      m.pos = chan;
      m.neg = 3'h0;
      m.neg_common = 1'b1;
    end
    return m;
  endfunction

endpackage

// ==== rtl/sync3.sv ====
/*
 * Three-stage synchroniser for a level entering a clock domain; the output
 * follows only once the second and third stages agree.
 * Assumes the input changes no faster than a few destination clocks.
 */
`timescale 1ns/100ps
module sync3 (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;
  logic stage2;
  logic stage3;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      meta <= d_i;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q_o <= 1'b0;
    end else if (stage2 == stage3) begin
      q_o <= stage3;
    end
  end
endmodule

// ==== tb/sra_checker.sv ====
/* concurrent checks on the core-side outputs of the front end.
   assumes it is bound to serial_register_access_front_end. */
`timescale 1ns/100ps
module sra_checker
  import sra_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wr_strobe_o,
  input wire logic [5:0] wr_addr_o,
  input wire logic [23:0] wr_data_o,
  input wire logic rd_strobe_o,
  input wire logic [5:0] rd_addr_o,
  input wire logic soft_reset_o,
  input wire logic [7:0] mode_o,
  input wire logic [2:0] mode_channel_o,
  input wire logic [2:0] pos_input_o,
  input wire logic [2:0] neg_input_o,
  input wire logic neg_is_common_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////
  property p_wr_pulse;
    wr_strobe_o |=> !wr_strobe_o;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
  property p_rd_pulse;
    rd_strobe_o |=> !rd_strobe_o;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
  property p_soft_pulse;
    soft_reset_o |=> !soft_reset_o;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset too long");
  property p_soft_mode;
    soft_reset_o |-> ##[0:2] (mode_o == MODE_RESET);
  endproperty
  a_soft_mode: assert property (p_soft_mode) else $error("mode kept on resync");
  property p_setup_width;
    wr_strobe_o && wr_addr_o[5:3] == GRP_SETUP |-> wr_data_o[23:8] == 16'h0000;
  endproperty
  a_setup_width: assert property (p_setup_width) else $error("setup write too wide");
  property p_mode_write;
    wr_strobe_o && wr_addr_o[5:3] == GRP_MODE |->
      ##[0:4] (mode_o == wr_data_o[7:0] && mode_channel_o == wr_addr_o[2:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");
  property p_map;
    wr_strobe_o && wr_addr_o[5:3] == GRP_MODE |-> ##[0:6] (mode_channel_o == wr_addr_o[2:0]
      && (neg_is_common_o ? pos_input_o == wr_addr_o[2:0] : (pos_input_o ==
      {wr_addr_o[1:0], 1'b0} && neg_input_o == {wr_addr_o[1:0], 1'b1})));
  endproperty
  a_map: assert property (p_map) else $error("input mapping wrong");
  property p_rd_fold;
    rd_strobe_o |-> rd_addr_o[5:3] != GRP_MODE || rd_addr_o[2:0] == 3'h0;
  endproperty
  a_rd_fold: assert property (p_rd_fold) else $error("mode read not at base");
  property p_reset;
    disable iff (1'b0) reset_i |=> !wr_strobe_o && !rd_strobe_o && mode_o == MODE_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs active in reset");
endmodule
bind serial_register_access_front_end sra_checker i_chk (.clk_i(clk_i), .reset_i(reset_i),
  .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
  .rd_strobe_o(rd_strobe_o), .rd_addr_o(rd_addr_o), .soft_reset_o(soft_reset_o),
  .mode_o(mode_o), .mode_channel_o(mode_channel_o), .pos_input_o(pos_input_o),
  .neg_input_o(neg_input_o), .neg_is_common_o(neg_is_common_o));

// ==== tb/host_model.sv ====
/* host model driving the serial port, 32 ns serial clock.
   assumes the front end samples din on rising and drives dout on falling edges. */
`timescale 1ns/100ps
module host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  input wire logic dout_i
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  task automatic pulses(input int n);
    repeat (n) begin
      #16 sclk_o = 1'b0;
      #16 sclk_o = 1'b1;
    end
  endtask
  // n bits from bit 31 down, with read turnaround after the command
  task automatic shift(input logic [31:0] v, input int n, output logic [31:0] g);
    g = '0;
    #16 cs_n_o = 1'b0;
    for (int i = 31; i > 31 - n; i--) begin
      #16 sclk_o = 1'b0;
      din_o = v[i];
      #16 sclk_o = 1'b1;
      g[i] = dout_i;
      if (i == 24) begin
        #300;
      end
    end
    #16 cs_n_o = 1'b1;
    din_o = ~din_o;
  endtask
  task automatic frame(input logic [7:0] c, input logic [23:0] d, input int w,
                       output logic [23:0] got);
    logic [31:0] v;
    logic [31:0] g;
    v = {c & 8'h7F, 24'h0} | ({8'h0, d} << (24 - w));
    if (c[6]) begin
      v[23:0] = 24'h0;
    end
    shift(v, 8 + w, g);
    got = g[23:0] >> (24 - w);
  endtask
  task automatic resync();
    logic [31:0] g;
    shift(32'hFFFF_FFFF, 32, g);
  endtask
endmodule

// ==== tb/testbench.sv ====
/* self-checking bench: register frames through the host model.
   assumes host_model and the bound sra_checker are compiled first. */
`timescale 1ns/100ps
module testbench;
  import sra_pkg::*;
  logic clk_i, reset_i, sclk_i, cs_n_i, din_i, dout_o, wr_strobe_o, rd_strobe_o;
  logic soft_reset_o, neg_is_common_o;
  logic [5:0] wr_addr_o, rd_addr_o;
  logic [23:0] wr_data_o, rd_data_i, got;
  logic [7:0] mode_o;
  logic [2:0] mode_channel_o, pos_input_o, neg_input_o;
  int fail_count = 0;
  int compares = 0;
  int tot = 0;
  wire [23:0] map_w = {14'h0, mode_channel_o, pos_input_o, neg_input_o, neg_is_common_o};
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (wr_strobe_o | rd_strobe_o | soft_reset_o) tot <= tot + 1;
  end
  host_model i_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o));
  serial_register_access_front_end i_dut (.clk_i(clk_i), .reset_i(reset_i),
    .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i), .dout_o(dout_o),
    .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .rd_strobe_o(rd_strobe_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
    .soft_reset_o(soft_reset_o), .mode_o(mode_o), .mode_channel_o(mode_channel_o),
    .pos_input_o(pos_input_o), .neg_input_o(neg_input_o), .neg_is_common_o(neg_is_common_o));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // bounded wait for the n-th strobe, then let mapping land
  task automatic wt(input int n);
    for (int k = 0; k < 40 && tot < n; k++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
    chk("strobes", 24'(n), 24'(tot));
  endtask
  task automatic wr(input logic [7:0] c, input logic [23:0] d, input int w, input int n);
    i_host.frame(c, d, w, got);
    wt(n);
    chk("dout", 24'h0, got);
    chk("wr_addr", {18'h0, c[5:0]}, {18'h0, wr_addr_o});
    chk("wr_data", d, wr_data_o);
  endtask
  task automatic rd(input logic [7:0] c, input int w, input int n, input logic [23:0] e);
    i_host.frame(c, 24'h0, w, got);
    wt(n);
    chk("rd_addr", {18'h0, c[5:0]}, {18'h0, rd_addr_o});
    chk("rd_data", e, got);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #60000;
    fail_count++;
    stop_test;
  end
  initial begin
    reset_i = 1'b1;
    rd_data_i = 24'hA5C3E1;
    fork
      i_host.pulses(6);
      repeat (8) @(posedge clk_i);
    join
    @(posedge clk_i);
    reset_i <= 1'b0;
    i_host.pulses(4);
    wr(8'h29, 24'h20, 8, 1);
    wr(8'h39, 24'h02, 8, 2);
    chk("mode", 24'h02, {16'h0, mode_o});
    chk("map", {14'h0, 3'h1, 3'h1, 3'h0, 1'b1}, map_w);
    wr(8'h3D, 24'h02, 8, 3);
    chk("map", {14'h0, 3'h5, 3'h2, 3'h3, 1'b0}, map_w);
    wr(8'h10, 24'hABCDEF, 24, 4);
    $display("test writes done");
    rd(8'h48, 24, 5, 24'hA5C3E1);
    @(posedge clk_i) rd_data_i <= 24'h00005A;
    rd(8'h78, 8, 6, 24'h00005A);
    $display("test reads done");
    i_host.resync();
    wt(9);
    chk("mode", 24'h0, {16'h0, mode_o});
    i_host.pulses(4);
    wr(8'h2A, 24'h40, 8, 10);
    $display("test resync done");
    stop_test;
  end
endmodule
